// ### hdl/pcg_pack_config.sv
// Purpose: Pack topology register, mux decode, scan settle and pin readback.
// Assumes: The serial front end delivers decoded register requests and the
//          two capture strobes as one-cycle pulses on this clock.
// Notes: Decoded mux controls follow the register one cycle later.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// R1: Four-bit read field reports each active pin input level, one for high.
// R2: Pins whose digital enable is clear read zero; enabled pins seen, except bits 1:0 under R5.
// R3: UART reads capture pin levels at end of address byte parity bit.
// R4: SPI reads capture pin levels on the ninth serial clock rising edge.
// R5: With the I2C master enabled, the two lowest pin bits read 00.
// R6: Two flex enable copies at bits 15 and 14, each resetting to one.
// R7: Both enable copies zero disables supply and block mux selection.
// R8: Disagreeing enable copies count as enabled, supply mux forced off.
// R9: Enabled with cell 0x8 to 0xE connects that tap to supply input.
// R10: Unsupported cell codes open all tap switches, leave common switch on.
// R11: Block field picks divider pin; 0x0 to 0x7 map to 0xF.
// R12: Block selection is ignored when the effective enable is zero.
// R13: With scan option set, alternate mux scans wait 30 us before sampling.
// R14: Delay only with flex enabled, supported cell and alternate mux set.
// R15: Scan option at bit 13 resets to one; clear leaves scan unchanged.
// R16: Disagreeing cell copies mask no alerts and force supply mux off.
// R17: Effective cell code selects alert masking; 0xF removes all masking.
// R18: Writes to pin field ignored; writable fields read back as written.
module pcg_pack_config (
    input wire logic clk,
    input wire logic srst,
    input wire pcg_pkg::pcg_req_s req,
    input wire logic uart_parity_end,
    input wire logic spi_ninth_rise,
    input wire logic [pcg_pkg::PIN_COUNT-1:0] pin_async,
    input wire logic [pcg_pkg::PIN_COUNT-1:0] digital_pin_enable,
    input wire logic i2c_master_enable,
    input wire logic alternate_mux_select,
    input wire logic top_cell_sample_req,
    output logic [15:0] rd_data,
    output logic rd_valid,
    output pcg_pkg::pcg_mux_s mux_ctl,
    output logic scan_settling,
    output logic top_cell_sample_go
);

    function automatic logic sel_supported(input logic [3:0] sel);
        return (sel >= pcg_pkg::SEL_MIN) && (sel <= pcg_pkg::SEL_MAX);
    endfunction : sel_supported

    logic [pcg_pkg::PIN_COUNT-1:0] pin_sync;
    logic [pcg_pkg::PIN_COUNT-1:0] pin_cap;
    logic [pcg_pkg::PIN_COUNT-1:0] next_pin_cap;
    logic [15:0] cfg;
    logic [15:0] next_cfg;
    logic [15:0] next_rd_data;
    logic next_rd_valid;
    pcg_pkg::pcg_mux_s next_mux_ctl;
    pcg_pkg::pcg_scan_e state;
    pcg_pkg::pcg_scan_e next_state;
    logic [pcg_pkg::SETTLE_CNT_W-1:0] cnt;
    logic [pcg_pkg::SETTLE_CNT_W-1:0] next_cnt;
    logic next_scan_settling;
    logic next_go;

    logic en_a;
    logic en_b;
    logic eff_en;
    logic en_agree;
    logic [3:0] cell_a;
    logic [3:0] cell_b;
    logic [3:0] block_sel;
    logic cell_agree;
    logic cell_ok;
    logic delay_applies;

    pcg_pin_sync #(
        .WIDTH(pcg_pkg::PIN_COUNT)
    ) u_pin_sync (
        .clk(clk),
        .srst(srst),
        .pin_async(pin_async),
        .pin_level(pin_sync)
    );

    assign en_a = cfg[pcg_pkg::FLEX_EN_A_POS];
    assign en_b = cfg[pcg_pkg::FLEX_EN_B_POS];
    assign cell_a = cfg[pcg_pkg::CELL_A_LSB +: 4];
    assign cell_b = cfg[pcg_pkg::CELL_B_LSB +: 4];
    assign block_sel = cfg[pcg_pkg::BLOCK_SEL_LSB +: 4];
    assign eff_en = en_a | en_b; // R7 R8
    assign en_agree = (en_a == en_b);
    assign cell_agree = (cell_a == cell_b); // R16
    assign cell_ok = cell_agree && sel_supported(cell_a);
    assign delay_applies = cfg[pcg_pkg::FLEX_SCAN_POS] && eff_en && cell_ok
        && alternate_mux_select; // R13 R14 R15

    // Register file and pin capture.
    always_comb begin
        next_cfg = cfg;
        next_pin_cap = pin_cap;
        next_rd_data = 16'h0000;
        next_rd_valid = req.rd_en;
        if (req.wr_en && req.addr == pcg_pkg::PTC_OFFSET) begin
            next_cfg = req.wdata & pcg_pkg::PTC_WRITE_MASK; // R6 R18
        end
        if (uart_parity_end || spi_ninth_rise) begin
            next_pin_cap = pin_sync; // R3 R4
        end
        if (req.rd_en) begin
            if (req.addr == pcg_pkg::PTC_OFFSET) begin
                next_rd_data = cfg; // R18
            end else if (req.addr == pcg_pkg::PIN_LEVEL_OFFSET) begin
                next_rd_data[pcg_pkg::PIN_COUNT-1:0] =
                    pin_cap & digital_pin_enable; // R1 R2
                if (i2c_master_enable) begin
                    next_rd_data[1:0] = 2'b00; // R5
                end
            end else begin
                next_rd_data = 16'h0000;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cfg <= pcg_pkg::PTC_RESET; // R6 R15
            pin_cap <= '0;
            rd_data <= 16'h0000;
            rd_valid <= 1'b0;
        end else begin
            cfg <= next_cfg;
            pin_cap <= next_pin_cap;
            rd_data <= next_rd_data;
            rd_valid <= next_rd_valid;
        end
    end

    // Mux decode.
    always_comb begin
        next_mux_ctl.supply_input_mux = pcg_pkg::SEL_OFF;
        next_mux_ctl.tap_connect = 1'b0;
        next_mux_ctl.common_on = 1'b0;
        next_mux_ctl.block_divider_mux = pcg_pkg::SEL_OFF;
        next_mux_ctl.alert_mask_sel = cell_agree ? cell_a
            : pcg_pkg::SEL_OFF; // R16 R17
        if (eff_en) begin
            if (en_agree && cell_ok) begin
                next_mux_ctl.supply_input_mux = cell_a; // R9
                next_mux_ctl.tap_connect = 1'b1;
            end else begin
                next_mux_ctl.common_on = 1'b1; // R8 R10 R16
            end
            if (sel_supported(block_sel)) begin
                next_mux_ctl.block_divider_mux = block_sel; // R11
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mux_ctl.supply_input_mux <= pcg_pkg::SEL_OFF;
            mux_ctl.tap_connect <= 1'b0;
            mux_ctl.common_on <= 1'b1;
            mux_ctl.block_divider_mux <= pcg_pkg::SEL_OFF;
            mux_ctl.alert_mask_sel <= pcg_pkg::SEL_OFF;
        end else begin
            mux_ctl <= next_mux_ctl; // R7 R12
        end
    end

    // Top-cell sampling with optional settle delay.
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_go = 1'b0;
        case (state)
            pcg_pkg::SCAN_IDLE: begin
                if (top_cell_sample_req) begin
                    if (delay_applies) begin
                        next_state = pcg_pkg::SCAN_SETTLE; // R13
                        next_cnt = pcg_pkg::SETTLE_CNT_W'(
                            pcg_pkg::SETTLE_CYCLES - 1);
                    end else begin
                        next_go = 1'b1; // R14
                    end
                end
            end
            pcg_pkg::SCAN_SETTLE: begin
                if (cnt == '0) begin
                    next_state = pcg_pkg::SCAN_IDLE;
                    next_go = 1'b1;
                end else begin
                    next_cnt = cnt - 1'b1;
                end
            end
            default: begin
                next_state = pcg_pkg::SCAN_IDLE;
            end
        endcase
        next_scan_settling = (next_state == pcg_pkg::SCAN_SETTLE);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= pcg_pkg::SCAN_IDLE;
            cnt <= '0;
            scan_settling <= 1'b0;
            top_cell_sample_go <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            scan_settling <= next_scan_settling;
            top_cell_sample_go <= next_go;
        end
    end

    // Checks.
    localparam logic [pcg_pkg::SETTLE_CNT_W-1:0] SETTLE_LEN =
        pcg_pkg::SETTLE_CNT_W'(pcg_pkg::SETTLE_CYCLES);
    logic [pcg_pkg::SETTLE_CNT_W-1:0] settle_len;

    always_ff @(posedge clk) begin
        if (srst) begin
            settle_len <= '0;
        end else begin
            settle_len <= scan_settling ? settle_len + 1'b1 : '0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_cfg_reset_val: assert property ( // R6
        $fell(srst) |-> cfg == pcg_pkg::PTC_RESET)
        else $error("Pack config reset value wrong.");
    a_cfg_wr_back: assert property ( // R18
        req.wr_en && req.addr == pcg_pkg::PTC_OFFSET && !req.rd_en
        ##1 req.rd_en && req.addr == pcg_pkg::PTC_OFFSET && !req.wr_en
        |=> rd_data == ($past(req.wdata, 2) & pcg_pkg::PTC_WRITE_MASK))
        else $error("Pack config did not read back write.");
    a_pin_ro_field: assert property ( // R18
        req.wr_en && !uart_parity_end && !spi_ninth_rise |=> $stable(pin_cap))
        else $error("Pin capture changed by a write.");
    a_uart_capture: assert property ( // R3
        uart_parity_end |=> pin_cap == $past(pin_sync))
        else $error("UART capture missed.");
    a_spi_capture: assert property ( // R4
        spi_ninth_rise |=> pin_cap == $past(pin_sync))
        else $error("SPI capture missed.");
    a_pin_disabled: assert property ( // R2
        req.rd_en && req.addr == pcg_pkg::PIN_LEVEL_OFFSET
        |=> (rd_data[3:0] & ~$past(digital_pin_enable)) == 4'h0
            && rd_data[15:4] == 12'h000)
        else $error("Disabled pin read nonzero.");
    a_i2c_low_zero: assert property ( // R5
        req.rd_en && req.addr == pcg_pkg::PIN_LEVEL_OFFSET && i2c_master_enable
        |=> rd_data[1:0] == 2'b00)
        else $error("I2C pins not read as zero.");
    a_flex_disabled: assert property ( // R7 R12
        !en_a && !en_b |=> !mux_ctl.common_on && !mux_ctl.tap_connect
            && mux_ctl.block_divider_mux == pcg_pkg::SEL_OFF)
        else $error("Flex functions active while disabled.");
    a_en_disagree: assert property ( // R8
        en_a != en_b |=> !mux_ctl.tap_connect && mux_ctl.common_on
            && mux_ctl.supply_input_mux == pcg_pkg::SEL_OFF)
        else $error("Supply mux not off on enable mismatch.");
    a_cell_connect: assert property ( // R9
        en_a && en_b && cell_ok |=> mux_ctl.tap_connect
            && mux_ctl.supply_input_mux == $past(cell_a))
        else $error("Supported cell not connected.");
    a_alert_mask: assert property ( // R16 R17
        !cell_agree |=> mux_ctl.alert_mask_sel == pcg_pkg::SEL_OFF)
        else $error("Alert masking on cell mismatch.");
    a_settle_length: assert property ( // R13
        top_cell_sample_go && $past(scan_settling) |-> settle_len == SETTLE_LEN)
        else $error("Settle delay wrong length.");
    a_no_delay_go: assert property ( // R14
        state == pcg_pkg::SCAN_IDLE && top_cell_sample_req && !delay_applies
        |=> top_cell_sample_go && !scan_settling)
        else $error("Undelayed sample not issued next cycle.");
    a_rd_valid_follow: assert property ( // R18
        rd_valid == $past(req.rd_en))
        else $error("Read answer not one cycle after request.");
    a_common_unsup: assert property ( // R10
        eff_en && !cell_ok |=> mux_ctl.common_on && !mux_ctl.tap_connect
            && mux_ctl.supply_input_mux == pcg_pkg::SEL_OFF)
        else $error("Unsupported cell did not select common switch.");
    a_block_unsup: assert property ( // R11
        eff_en && block_sel < pcg_pkg::SEL_MIN
        |=> mux_ctl.block_divider_mux == pcg_pkg::SEL_OFF)
        else $error("Unsupported block code not mapped to dedicated pin.");
    a_block_connect: assert property ( // R11
        eff_en && sel_supported(block_sel)
        |=> mux_ctl.block_divider_mux == $past(block_sel))
        else $error("Supported block code not routed.");
    a_settle_quiet: assert property ( // R13
        state == pcg_pkg::SCAN_SETTLE && cnt != '0 |=> !top_cell_sample_go)
        else $error("Sample issued before settle delay ended.");

    c_uart_read: cover property (uart_parity_end ##1 rd_valid);
    c_spi_read: cover property (spi_ninth_rise ##1 rd_valid);
    c_settle_done: cover property (scan_settling ##1 top_cell_sample_go);
    c_en_mismatch: cover property (en_a != en_b);
    c_block_route: cover property (eff_en && sel_supported(block_sel));

endmodule : pcg_pack_config
`default_nettype wire

// ### hdl/pcg_pin_sync.sv
// Purpose: Brings the general-purpose pin levels into the core clock domain.
// Assumes: Pins change slowly compared with the core clock.
// Notes: A bit updates only when the second and third stages agree.
`timescale 1ns/100ps
`default_nettype none

module pcg_pin_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [WIDTH-1:0] pin_async,
    output logic [WIDTH-1:0] pin_level
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic s1;
            logic s2;
            logic s3;
            logic level;
            logic next_level;

            always_comb begin
                next_level = (s2 == s3) ? s3 : level;
            end

            always_ff @(posedge clk) begin
                if (srst) begin
                    s1 <= 1'b0;
                    s2 <= 1'b0;
                    s3 <= 1'b0;
                    level <= 1'b0;
                end else begin
                    s1 <= pin_async[i];
                    s2 <= s1;
                    s3 <= s2;
                    level <= next_level;
                end
            end

            assign pin_level[i] = level;
        end
    endgenerate

endmodule : pcg_pin_sync
`default_nettype wire

// ### hdl/pcg_pkg.sv
// Purpose: Shared constants and carriers for the pack configuration block.
// Assumes: Register offsets are register indices on the host access port.
// Notes: All timing counts derive from the 125 MHz core clock.
package pcg_pkg;

    localparam logic [7:0] PIN_LEVEL_OFFSET = 8'h17;
    localparam logic [7:0] PTC_OFFSET = 8'h18;

    localparam int FLEX_EN_B_POS = 15;
    localparam int FLEX_EN_A_POS = 14;
    localparam int FLEX_SCAN_POS = 13;
    localparam int BLOCK_SEL_LSB = 8;
    localparam int CELL_B_LSB = 4;
    localparam int CELL_A_LSB = 0;
    localparam int PIN_COUNT = 4;

    localparam logic [15:0] PTC_RESET = 16'hEFFF;
    localparam logic [15:0] PTC_WRITE_MASK = 16'hEFFF;

    localparam logic [3:0] SEL_OFF = 4'hF;
    localparam logic [3:0] SEL_MIN = 4'h8;
    localparam logic [3:0] SEL_MAX = 4'hE;

    localparam int CLK_MHZ = 125;
    localparam int SCAN_SETTLE_US = 30;
    localparam int SETTLE_CYCLES = SCAN_SETTLE_US * CLK_MHZ;
    localparam int SETTLE_CNT_W = 12;

    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [7:0] addr;
        logic [15:0] wdata;
    } pcg_req_s;

    typedef struct packed {
        logic [3:0] supply_input_mux;
        logic tap_connect;
        logic common_on;
        logic [3:0] block_divider_mux;
        logic [3:0] alert_mask_sel;
    } pcg_mux_s;

    typedef enum logic [0:0] {
        SCAN_IDLE,
        SCAN_SETTLE
    } pcg_scan_e;

endpackage : pcg_pkg

// ### test/pcg_host.sv
// Purpose: Host model that issues register requests and capture strobes.
// Assumes: Serial framing is already decoded into one-cycle pulses.
// Notes: Every request changes just after a falling clock edge.
`timescale 1ns/100ps
`default_nettype none

module pcg_host (
    input wire logic clk,
    output var pcg_pkg::pcg_req_s req,
    output logic uart_parity_end,
    output logic spi_ninth_rise,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid
);
    initial begin
        req = '0;
        uart_parity_end = 1'b0;
        spi_ninth_rise = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        req <= '0;
    endtask : wr

    // The answer stands one cycle after the request, so it is taken here.
    task automatic rd(input logic [7:0] a, output logic [15:0] d,
                      output logic v);
        @(negedge clk);
        req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 16'h0000};
        @(negedge clk);
        req <= '0;
        v = rd_valid;
        d = rd_data;
    endtask : rd

    // Write then read in the very next cycle, as the port allows.
    task automatic wr_rd(input logic [7:0] a, input logic [15:0] wd,
                         output logic [15:0] d);
        @(negedge clk);
        req <= '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: wd};
        @(negedge clk);
        req <= '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 16'h0000};
        @(negedge clk);
        req <= '0;
        d = rd_data;
    endtask : wr_rd

    task automatic cap(input logic spi);
        @(negedge clk);
        uart_parity_end <= !spi;
        spi_ninth_rise <= spi;
        @(negedge clk);
        uart_parity_end <= 1'b0;
        spi_ninth_rise <= 1'b0;
    endtask : cap
endmodule : pcg_host

`default_nettype wire

// ### test/pcg_pack_config_tb.sv
// Purpose: Self-checking bench for the pack configuration block.
// Assumes: The host model drives the register port and capture strobes.
// Notes: Expected values come from a small model of the decode.
`timescale 1ns/100ps
`default_nettype none

`define CHK(n, e, s) begin \
    checks_done++; \
    if ((s) !== (e)) begin \
        err_count++; \
        $display("mismatch %s exp %0h got %0h", n, e, s); \
    end \
end

module pcg_pack_config_tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    pcg_pkg::pcg_req_s req;
    logic uart_parity_end;
    logic spi_ninth_rise;
    logic [3:0] pin_async = 4'h0;
    logic [3:0] pin_en = 4'h0;
    logic i2c_en = 1'b0;
    logic alt_sel = 1'b0;
    logic sample_req = 1'b0;
    logic [15:0] rd_data;
    logic rd_valid;
    pcg_pkg::pcg_mux_s mux_ctl;
    logic scan_settling;
    logic go;
    int err_count = 0;
    int checks_done = 0;
    integer seed = 19617;
    logic [15:0] w;
    logic [15:0] d;
    logic v;
    int n;
    logic [15:0] dirs [9] = '{16'h0000, 16'h4088, 16'hC08E, 16'hC098,
                              16'hC5FF, 16'hCA88, 16'hFFFF, 16'h80EE,
                              16'h2A88};
    logic [15:0] scn [5] = '{16'hE088, 16'hC088, 16'hE088, 16'hA0EE,
                             16'hE077};
    logic [4:0] dmask = 5'h09;

    always #4 clk = ~clk;

    pcg_pack_config DUT (
        .clk(clk), .srst(srst), .req(req),
        .uart_parity_end(uart_parity_end), .spi_ninth_rise(spi_ninth_rise),
        .pin_async(pin_async), .digital_pin_enable(pin_en),
        .i2c_master_enable(i2c_en), .alternate_mux_select(alt_sel),
        .top_cell_sample_req(sample_req), .rd_data(rd_data),
        .rd_valid(rd_valid), .mux_ctl(mux_ctl),
        .scan_settling(scan_settling), .top_cell_sample_go(go)
    );

    pcg_host host (
        .clk(clk), .req(req), .uart_parity_end(uart_parity_end),
        .spi_ninth_rise(spi_ninth_rise), .rd_data(rd_data),
        .rd_valid(rd_valid)
    );

    task automatic results();
        if (err_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    task automatic chk_mux(input logic [15:0] c);
        logic [3:0] ca;
        logic [3:0] cb;
        logic [3:0] blk;
        logic en;
        logic tap;
        ca = c[3:0];
        cb = c[7:4];
        en = c[15] | c[14];
        tap = en && c[15] == c[14] && ca == cb && ca >= 4'h8 && ca <= 4'hE;
        blk = (en && c[11:8] >= 4'h8) ? c[11:8] : 4'hF;
        `CHK("supply", tap ? ca : 4'hF, mux_ctl.supply_input_mux)
        `CHK("tap", tap, mux_ctl.tap_connect)
        `CHK("common", en && !tap, mux_ctl.common_on)
        `CHK("block", blk, mux_ctl.block_divider_mux)
        `CHK("alert", ca == cb ? ca : 4'hF, mux_ctl.alert_mask_sel)
    endtask : chk_mux

    initial begin
        #200000;
        err_count++;
        results();
    end

    initial begin
        repeat (20) @(negedge clk);
        srst = 1'b0;
        chk_mux(16'hEFFF);
        host.rd(8'h18, d, v);
        `CHK("cfg_reset", 16'hEFFF, d)
        // Corner codes first, then random words, all read back and decoded.
        for (int i = 0; i < 40; i++) begin
            w = (i < 9) ? dirs[i] : 16'($random(seed));
            host.wr(8'h18, w);
            host.rd(8'h18, d, v);
            `CHK("valid", 1'b1, v)
            `CHK("cfg", w & 16'hEFFF, d)
            chk_mux(w);
        end
        host.wr(8'h40, 16'h1234);
        host.rd(8'h40, d, v);
        `CHK("unmapped", 16'h0000, d)
        host.rd(8'h18, d, v);
        `CHK("cfg_kept", w & 16'hEFFF, d)
        host.wr_rd(8'h18, 16'h5A5A, d);
        `CHK("wr_rd", 16'h4A5A, d)
        // Pins flip after the strobe, so only the captured levels may show.
        for (int i = 0; i < 16; i++) begin
            pin_async = 4'($random(seed));
            pin_en = 4'($random(seed));
            i2c_en = i[0];
            w = {12'h000, pin_async & pin_en};
            if (i2c_en) w[1:0] = 2'b00;
            repeat (6) @(negedge clk);
            host.cap(i[1]);
            pin_async = ~pin_async;
            repeat (4) @(negedge clk);
            host.wr(8'h17, 16'($random(seed)));
            host.rd(8'h17, d, v);
            `CHK("pins", w, d)
        end
        for (int k = 0; k < 5; k++) begin
            host.wr(8'h18, scn[k]);
            alt_sel = (k != 2);
            @(negedge clk);
            sample_req = 1'b1;
            @(negedge clk);
            sample_req = 1'b0;
            `CHK("settling", dmask[k], scan_settling)
            n = 0;
            while (go !== 1'b1 && n < 5000) begin
                @(negedge clk);
                n++;
            end
            `CHK("delay", dmask[k] ? 3750 : 0, n)
        end
        results();
    end
endmodule : pcg_pack_config_tb

`default_nettype wire
